/* File: pkg/ssp_params.svh */
// Offsets, field positions, reset values for the serial shift port.
// Assumes inclusion by bare name from the design files.
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
// Register indexes as printed; byte address is four times the index
`define SSP_IDX_IRQ_DISABLE 8'hC2
`define SSP_IDX_SHIFT_DATA 8'hDD
`define SSP_IDX_PORT_CTRL 8'hE0
`define SSP_IDX_PORT_STAT 8'hE1
`define SSP_IDX_IRQ_STATUS 8'hE2
`define SSP_IDX_IRQ_MASK 8'hE3
// Port control field positions
`define SSP_CTL_SCL_OUT 0
`define SSP_CTL_SCL_DAT 1
`define SSP_CTL_SOUT_OD 2
`define SSP_CTL_SIN_PULL 3
`define SSP_CTL_SOUT_DAT 4
// Port status field positions
`define SSP_STA_SIN 0
`define SSP_STA_SCL 1
`define SSP_STA_ARMED 2
`define SSP_STA_DONE 3
// Event bit positions
`define SSP_EV_BYTE 0
`define SSP_EV_EDGE 1
// Reset values
`define SSP_CTRL_RST 8'h00
`define SSP_MASK_RST 8'h00
// Bits in one serial byte
`define SSP_BITS 4'h8
`endif

/* File: pkg/ssp_pkg.sv */
// Types for the serial shift port.
// Assumes nothing of its surroundings.
package ssp_pkg;
    // Bus answer phase
    typedef enum logic [0:0] {SSP_IDLE, SSP_ACK} ssp_bus_e;
endpackage

/* File: verilog/ssp_sync.sv */
// Two-stage synchroniser for a pin level.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/100ps
module ssp_sync
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Pin level in, synchronised level out
    input wire logic pin_in,
    output logic pin_sync
);
    logic meta_r; // First stage, read only by the second

    // Two flops in series
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            meta_r <= 1'b0;
            pin_sync <= 1'b0;
        end
        else
        begin
            meta_r <= pin_in;
            pin_sync <= meta_r;
        end
    end
endmodule

/* File: verilog/ssp_top.sv */
// Serial shift port: 8-bit shift register, bit counter, pins, Wishbone.
// Assumes classic Wishbone master on ref_clk; pins are asynchronous.
//
// Behaviour
// - Eight-bit shifter, four-bit counter, falling edges
// - Shift MSB first, in on sin
// - After eight pulses counter blocks further clocking
// - Interrupt on eighth falling edge unless rewritten
// - Interrupt disabled after reset until write
// - Shift register write arms interrupt
// - Any write to disable register disarms
// - Interrupt request is a falling transition
// - Reset or write clears counter, enables clock
// - Master mode: software toggles clock output
// - sin input, sout open-drain for transmit
// - Open-drain sout carries shifter output
// - Sin level readable for collision checks
// - Slave may stretch clock by holding low
// - Software may pull data low for acknowledge
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
`include "ssp_params.svh"
module ssp_top
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial clock pin
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    // Serial input pin (open-drain pull for acknowledge)
    input wire logic sin_i,
    output logic sin_o,
    output logic sin_oe,
    // Serial output pin, open drain
    input wire logic sout_i,
    output logic sout_o,
    output logic sout_oe,
    // Falling-edge serial request to the core
    output logic serial_irq_n,
    // Level interrupt from status and mask
    output logic irq
);
    logic scl_s; // Synchronised clock pin
    logic sin_s; // Synchronised data pin
    logic scl_prev_r; // Last clock level for edge finding
    logic [7:0] shift_r; // Data shift register
    logic [3:0] count_r; // Bit counter
    logic armed_r; // Interrupt armed
    logic [7:0] ctrl_r; // Port control
    logic [1:0] stat_r; // Sticky events
    logic [1:0] mask_r; // Event mask
    logic irq_n_r; // Serial request level
    ssp_pkg::ssp_bus_e bus_r; // Bus answer phase
    logic fall; // Enabled falling edge of the clock
    logic count_done_output; // High while counter may still clock
    logic req; // Bus request this cycle
    logic wr; // Write with lowest lane enabled
    logic [7:0] idx; // Register index
    logic wr_data; // Write to shift register
    logic wr_dis; // Write to disable register
    logic byte_done; // Eighth edge this cycle
    logic [1:0] ev; // Event pulses

    // Pin synchronisers
    ssp_sync u_scl
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_in(scl_i),
        .pin_sync(scl_s)
    );
    ssp_sync u_sin
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_in(sin_i),
        .pin_sync(sin_s)
    );

    // Bus decode
    assign req = wb_cyc_i && wb_stb_i && (bus_r == ssp_pkg::SSP_IDLE);
    assign idx = wb_adr_i[9:2];
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign wr_data = wr && (idx == `SSP_IDX_SHIFT_DATA);
    assign wr_dis = wr && (idx == `SSP_IDX_IRQ_DISABLE);

    // Counter top output low once eight pulses are counted
    assign count_done_output = (count_r != `SSP_BITS);
    assign fall = scl_prev_r && !scl_s && count_done_output;
    assign byte_done = fall && (count_r == `SSP_BITS - 4'h1);
    assign ev = {fall, byte_done};

    // Clock edge finder
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            scl_prev_r <= 1'b0;
        else
            scl_prev_r <= scl_s;
    end

    // Shift register
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            shift_r <= 8'h00;
        else if (wr_data)
            shift_r <= wb_dat_i[7:0];
        else if (fall)
            shift_r <= {shift_r[6:0], sin_s};
    end

    // Bit counter
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            count_r <= 4'h0;
        else if (wr_data)
            count_r <= 4'h0;
        else if (fall)
            count_r <= count_r + 4'h1;
    end

    // Arming: write arms, disable write or reset disarms
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            armed_r <= 1'b0;
        else if (wr_data)
            armed_r <= 1'b1;
        else if (wr_dis)
            armed_r <= 1'b0;
    end

    // Serial request: low from eighth edge until rearm or disarm
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq_n_r <= 1'b1;
        else if (wr_data || wr_dis)
            irq_n_r <= 1'b1;
        else if (byte_done && armed_r)
            irq_n_r <= 1'b0;
    end
    assign serial_irq_n = irq_n_r;

    // Port control register
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ctrl_r <= `SSP_CTRL_RST;
        else if (wr && idx == `SSP_IDX_PORT_CTRL)
            ctrl_r <= wb_dat_i[7:0];
    end

    // Sticky status, set wins over write-one clear
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            stat_r <= 2'h0;
        else if (wr && idx == `SSP_IDX_IRQ_STATUS)
            stat_r <= (stat_r & ~wb_dat_i[1:0]) | ev;
        else
            stat_r <= stat_r | ev;
    end

    // Mask register
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            mask_r <= 2'h0;
        else if (wr && idx == `SSP_IDX_IRQ_MASK)
            mask_r <= wb_dat_i[1:0];
    end
    assign irq = |(stat_r & mask_r);

    // Clock pin: output when master, or held low to stretch
    assign scl_o = ctrl_r[`SSP_CTL_SCL_DAT];
    assign scl_oe = ctrl_r[`SSP_CTL_SCL_OUT]
        && !ctrl_r[`SSP_CTL_SCL_DAT];

    // Data in pin stays input unless software pulls it low
    assign sin_o = 1'b0;
    assign sin_oe = ctrl_r[`SSP_CTL_SIN_PULL];

    // Open-drain out: shifter MSB, else port bit when not open drain
    assign sout_o = 1'b0;
    assign sout_oe = ctrl_r[`SSP_CTL_SOUT_OD] ? !shift_r[7]
        : !ctrl_r[`SSP_CTL_SOUT_DAT];

    // Bus answer: one wait, ack for one cycle
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            bus_r <= ssp_pkg::SSP_IDLE;
        else if (req)
            bus_r <= ssp_pkg::SSP_ACK;
        else
            bus_r <= ssp_pkg::SSP_IDLE;
    end
    assign wb_ack_o = (bus_r == ssp_pkg::SSP_ACK);

    // Read data, registered with the request
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            wb_dat_o <= 32'h0000_0000;
        else if (req)
        begin
            case (idx)
                `SSP_IDX_SHIFT_DATA:
                    wb_dat_o <= {24'h000000, shift_r};
                `SSP_IDX_PORT_CTRL:
                    wb_dat_o <= {24'h000000, ctrl_r};
                `SSP_IDX_PORT_STAT:
                    wb_dat_o <= {28'h0000000, !count_done_output,
                        armed_r, scl_s, sin_s};
                `SSP_IDX_IRQ_STATUS:
                    wb_dat_o <= {30'h00000000, stat_r};
                `SSP_IDX_IRQ_MASK:
                    wb_dat_o <= {30'h00000000, mask_r};
                default:
                    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

/* File: sim/ssp_assertions.sv */
// Concurrent checks on the serial shift port's bus and pins.
// Assumes a single ref_clk domain; bound onto every ssp_top.
`timescale 1ns/100ps
module ssp_assertions
(
    // Watched ports
    input wire logic ref_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o, scl_i, scl_o, scl_oe, sin_o, sin_oe,
    input wire logic serial_irq_n, irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Write answered at this edge
    wire wr = wb_ack_o && wb_we_i;
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_prompt: assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o)
        else $error("ack late");
    a_read_upper: assert property (wb_ack_o && !wb_we_i |-> !wb_dat_o[31:8])
        else $error("upper read bits set");
    a_scl_low_only: assert property (scl_oe |-> !scl_o)
        else $error("clock pin driven high");
    a_sin_pull_low: assert property (sin_oe |-> !sin_o)
        else $error("data pin driven high");
    a_req_after_fall: assert property
        ($fell(serial_irq_n) |-> !scl_i && !$past(scl_i))
        else $error("request fell without clock fall");
    a_req_rise_write: assert property
        ($rose(serial_irq_n) |-> wr || $past(wr))
        else $error("request rose without write");
    a_irq_drop_write: assert property ($fell(irq) |-> wr || $past(wr))
        else $error("interrupt dropped without write");
endmodule
bind ssp_top ssp_assertions u_chk (.ref_clk, .sys_rst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .scl_i, .scl_o, .scl_oe,
    .sin_o, .sin_oe, .serial_irq_n, .irq);

/* File: sim/ssp_partner.sv */
// External serial master: makes the clock, sends and takes a byte.
// Assumes pull-ups on the lines; clock stands high between bytes.
`timescale 1ns/100ps
module ssp_partner
(
    // Pin levels
    input wire logic sout_line,
    output logic scl_drv,
    output logic sin_drv
);
    // Idle: clock high, data released
    initial
    begin
        scl_drv = 1'h1;
        sin_drv = 1'h1;
    end
    // One byte MSB first; hp is the half period in ns
    task automatic xfer(input logic [7:0] tx, input real hp,
                        output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sin_drv = tx[i];
            #(hp);
            rx[i] = sout_line;
            scl_drv = 1'h0;
            #(hp);
            scl_drv = 1'h1;
        end
        sin_drv = 1'h1;
    endtask
endmodule

/* File: sim/ssp_top_tb.sv */
// Self-checking bench for the serial shift port.
// Assumes the partner model on the pins and pull-ups on the lines.
`timescale 1ns/100ps
module ssp_top_tb;
    // Bus, pins and bookkeeping
    logic ref_clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0;
    logic [9:0] adr = 0;
    logic [31:0] wdat = 0, rdat, q[$];
    logic ack, scl_o, scl_oe, sin_o, sin_oe, sout_oe, irq_n, irq;
    logic scl_p, sin_p;
    logic [7:0] d, r, got;
    int num_errors = 0, n_checks = 0, seed = 48;
    ssp_top u_dut (.ref_clk, .sys_rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .scl_o, .scl_oe,
        .scl_i(scl_p & ~(scl_oe & ~scl_o)), .sin_o, .sin_oe,
        .sin_i(sin_p & ~(sin_oe & ~sin_o)), .sout_i(~sout_oe), .sout_o(),
        .sout_oe, .serial_irq_n(irq_n), .irq);
    ssp_partner u_part (.sout_line(~sout_oe), .scl_drv(scl_p),
        .sin_drv(sin_p));
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    // Compare and count
    task automatic chk(input string what, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", what, e, g);
        end
    endtask
    // One classic cycle; a read queues its expected value
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] v);
        if (!w)
            q.push_back(v);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= {idx, 2'h0};
        wdat <= v;
        @(posedge ref_clk);
        while (ack !== 1'h1)
            @(posedge ref_clk);
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge ref_clk);
    endtask
    // Read watcher: oldest note against each read answer
    always @(posedge ref_clk)
        if (ack === 1'h1 && we === 1'h0)
            chk("read", q.pop_front(), rdat);
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        #200000;
        num_errors++;
        finish_test();
    end
    // Main sequence
    initial
    begin
        d = 8'($random(seed));
        r = 8'($random(seed));
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'h0;
        @(posedge ref_clk);
        chk("irq", 2'h1, {irq, irq_n});
        bus(1, 8'h10, 32'hFF);
        bus(0, 8'h10, 32'h0);
        bus(0, 8'hE1, 32'h3);
        bus(1, 8'hE0, 32'h9);
        repeat (4) @(posedge ref_clk);
        bus(0, 8'hE1, 32'h0);
        bus(1, 8'hE0, 32'h4);
        bus(1, 8'hE3, 32'h1);
        bus(1, 8'hE2, 32'h3);
        bus(1, 8'hDD, {24'h0, d});
        u_part.xfer(r, 62.5, got);
        repeat (4) @(posedge ref_clk);
        chk("sout", {24'h0, d}, {24'h0, got});
        chk("irq", 2'h2, {irq, irq_n});
        bus(0, 8'hDD, {24'h0, r});
        u_part.xfer(~r, 62.5, got);
        repeat (4) @(posedge ref_clk);
        bus(0, 8'hDD, {24'h0, r});
        bus(1, 8'hE2, 32'h1);
        bus(1, 8'hC2, $random(seed));
        chk("irq", 2'h1, {irq, irq_n});
        bus(1, 8'hDD, 32'h0);
        bus(1, 8'hC2, 32'h0);
        u_part.xfer(d, 62.5, got);
        repeat (4) @(posedge ref_clk);
        chk("irq", 2'h3, {irq, irq_n});
        bus(0, 8'hDD, {24'h0, d});
        sys_rst <= 1'h1;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'h0;
        @(posedge ref_clk);
        u_part.xfer(r, 62.5, got);
        repeat (4) @(posedge ref_clk);
        chk("irq", 2'h1, {irq, irq_n});
        bus(0, 8'hDD, {24'h0, r});
        finish_test();
    end
endmodule
